// [rtl/scs_self_cal.sv]
// Self-calibration scheduler and actuator current compensation.
// Assumes host command, system area and measurement logic on ref_clk.
//
// Summary of operation
// - A self-calibration runs right after reset before the drive declares itself ready.
// - A recalibrate command from the host starts a self-calibration when the drive is ready and idle or in a timed calibration.
// - After power-on a self-calibration is repeated about every 30 minutes forever.
// - Timed calibrations fall due at 30, 60, 90, 120, 150 minutes of accumulated time and on.
// - A host command arriving during a timed calibration abandons it and starts at once.
// - When the pre-empting command has finished its disk work the calibration starts again.
// - The wait from command arrival to its start during a timed calibration stays under 100 ms.
// - The stored balancing current is added to the requested actuator current.
// - Force offsets are kept for 14 zones and updated from the system area factory values plus the measured offsets.
// - Loop-gain compensation is stored as measured gain over target gain.
// - The actuator current is multiplied by the gain ratio to keep loop gain constant.
// - Gain ratios are kept for 14 partitions, each the product of its system area value and the measured gain.
// - Ready, and with it host commands, comes only after the power-on calibration.
`include "scs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module scs_self_cal #(
  parameter int ZONES          = `SCS_ZONES,
  parameter int DW             = `SCS_DATA_W,
  parameter int TICK_CYCLES    = `SCS_TICK_CYCLES,
  parameter int INTERVAL_TICKS = `SCS_INTERVAL_TICKS
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Host command
  input  wire logic              cmd_req,
  input  wire logic              cmd_recal,
  input  wire logic              cmd_done,
  output var  logic              cmd_start_q,
  output var  logic              recal_done_q,
  output var  logic              drive_ready_q,
  output var  logic              cal_busy_q,
  // System area factory values
  output var  logic              sa_rd_req_q,
  output var  scs_pkg::scs_zone_t sa_zone_q,
  input  wire logic              sa_rd_valid,
  input  wire logic [DW-1:0]     sa_force,
  input  wire logic [DW-1:0]     sa_gain,
  // Measurement with disturbance injection
  output var  logic              dist_en_q,
  input  wire logic              meas_valid,
  input  wire logic [DW-1:0]     meas_force,
  input  wire logic [DW-1:0]     meas_gain,
  // Actuator current path
  input  wire logic              cur_valid,
  input  wire logic [DW-1:0]     cur_req,
  input  wire scs_pkg::scs_zone_t cur_zone,
  output var  logic              vcm_valid_q,
  output var  logic [DW-1:0]     vcm_cur_q
);
  import scs_pkg::*;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int MW = $clog2(INTERVAL_TICKS + 1);
  localparam scs_zone_t LAST_ZONE = scs_zone_t'(ZONES - 1);
  ////////////////////////////////////////////////////////////////////////////
  // Timechart from power-on
  logic [TW-1:0] tick_q;
  logic [MW-1:0] ms_q;
  wire           tick_wrap = (tick_q == TW'(TICK_CYCLES - 1));
  wire           due       = tick_wrap && (ms_q == MW'(INTERVAL_TICKS - 1));
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= '0;
      ms_q   <= '0;
    end else begin
      tick_q <= tick_wrap ? '0 : tick_q + TW'(1);
      if (tick_wrap) begin
        ms_q <= due ? '0 : ms_q + MW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scheduler
  scs_state_t st_q, st_d;
  scs_zone_t  zone_q, zone_d;
  logic       timed_q, timed_d, pend_q, go_sa;
  logic [DW-1:0] sa_force_q, sa_gain_q, m_force_q, m_gain_q;
  wire cal_act   = (st_q == ST_SA) || (st_q == ST_MEAS) || (st_q == ST_WR);
  wire accept    = cmd_req && drive_ready_q && ((st_q == ST_IDLE) || (cal_act && timed_q));
  wire recal_tk  = accept && cmd_recal;
  wire preempt   = accept && !cmd_recal && cal_act;
  wire cal_end   = (st_q == ST_WR) && (zone_q == LAST_ZONE) && !accept;
  wire pend_set  = due || preempt;
  wire pend_clr  = go_sa && (zone_d == '0) && !recal_tk;
  always_comb begin
    st_d    = st_q;
    zone_d  = zone_q;
    timed_d = timed_q;
    go_sa   = 1'b0;
    if (recal_tk) begin
      st_d    = ST_SA;
      zone_d  = '0;
      timed_d = 1'b0;
      go_sa   = 1'b1;
    end else if (accept) begin
      st_d = ST_CMD;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (pend_q) begin
            st_d    = ST_SA;
            zone_d  = '0;
            timed_d = drive_ready_q;
            go_sa   = 1'b1;
          end
        end
        ST_SA: begin
          if (sa_rd_valid) begin
            st_d    = ST_MEAS;
          end
        end
        ST_MEAS: begin
          if (meas_valid) begin
            st_d = ST_WR;
          end
        end
        ST_WR: begin
          if (zone_q == LAST_ZONE) begin
            st_d = ST_IDLE;
          end else begin
            st_d   = ST_SA;
            zone_d = zone_q + scs_zone_t'(1);
            go_sa  = 1'b1;
          end
        end
        ST_CMD: begin
          if (cmd_done && pend_q) begin
            st_d    = ST_SA;
            zone_d  = '0;
            timed_d = 1'b1;
            go_sa   = 1'b1;
          end else if (cmd_done) begin
            st_d = ST_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= ST_IDLE;
      zone_q  <= '0;
      timed_q <= 1'b0;
      pend_q  <= 1'b1;
    end else begin
      st_q    <= st_d;
      zone_q  <= zone_d;
      timed_q <= timed_d;
      pend_q  <= pend_set | (pend_q & ~pend_clr);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_start_q   <= 1'b0;
      recal_done_q  <= 1'b0;
      drive_ready_q <= 1'b0;
      cal_busy_q    <= 1'b0;
      sa_rd_req_q   <= 1'b0;
      sa_zone_q     <= '0;
      dist_en_q     <= 1'b0;
    end else begin
      cmd_start_q   <= accept && !cmd_recal;
      recal_done_q  <= cal_end && !timed_q && drive_ready_q;
      drive_ready_q <= drive_ready_q | cal_end;
      cal_busy_q    <= (st_d == ST_SA) || (st_d == ST_MEAS) || (st_d == ST_WR);
      sa_rd_req_q   <= go_sa;
      sa_zone_q     <= zone_d;
      dist_en_q     <= (st_d == ST_MEAS);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sa_force_q <= '0;
      sa_gain_q  <= '0;
      m_force_q  <= '0;
      m_gain_q   <= '0;
    end else begin
      if ((st_q == ST_SA) && sa_rd_valid) begin
        sa_force_q <= sa_force;
        sa_gain_q  <= sa_gain;
      end
      if ((st_q == ST_MEAS) && meas_valid) begin
        m_force_q <= meas_force;
        m_gain_q  <= meas_gain;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zone tables
  wire                 tbl_wr   = (st_q == ST_WR) && !accept;
  wire signed [DW:0]   f_sum    = $signed({sa_force_q[DW-1], sa_force_q})
                                  + $signed({m_force_q[DW-1], m_force_q});
  wire [2*DW-1:0]      g_prod   = sa_gain_q * m_gain_q;
  wire [2*DW-1:0]      g_shift  = g_prod >> `SCS_GAIN_FRAC;
  wire                 f_ovf    = (f_sum[DW] != f_sum[DW-1]);
  wire [DW-1:0]        f_wr     = f_ovf ? {f_sum[DW], {(DW-1){~f_sum[DW]}}}
                                        : f_sum[DW-1:0];
  wire [DW-1:0]        g_wr     = (|g_shift[2*DW-1:DW]) ? '1 : g_shift[DW-1:0];
  logic [DW-1:0]       force_rd, gain_rd;
  scs_zone_mem #(.W(DW), .DEPTH(ZONES), .AW(`SCS_ZONE_W), .INIT(`SCS_FORCE_ZERO)) u_force (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .wr_en     (tbl_wr),
    .wr_addr   (zone_q),
    .wr_data   (f_wr),
    .rd_addr   (cur_zone),
    .rd_data_q (force_rd)
  );
  scs_zone_mem #(.W(DW), .DEPTH(ZONES), .AW(`SCS_ZONE_W), .INIT(`SCS_GAIN_ONE)) u_gain (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .wr_en     (tbl_wr),
    .wr_addr   (zone_q),
    .wr_data   (g_wr),
    .rd_addr   (cur_zone),
    .rd_data_q (gain_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Actuator current compensation
  logic [DW-1:0] cur_s1_q;
  logic          val_s1_q;
  wire signed [2*DW:0]   c_prod  = $signed(cur_s1_q) * $signed({1'b0, gain_rd});
  wire signed [2*DW:0]   c_scl   = c_prod >>> `SCS_GAIN_FRAC;
  wire signed [2*DW+1:0] c_sum   = {c_scl[2*DW], c_scl}
                                   + {{(DW+2){force_rd[DW-1]}}, force_rd};
  wire                   c_hi    = (c_sum > $signed((2*DW+2)'({1'b0, {(DW-1){1'b1}}})));
  wire                   c_lo    = (c_sum < -$signed((2*DW+2)'({1'b1, {(DW-1){1'b0}}})));
  wire [DW-1:0]          c_out   = c_hi ? {1'b0, {(DW-1){1'b1}}}
                                 : c_lo ? {1'b1, {(DW-1){1'b0}}} : c_sum[DW-1:0];
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_s1_q    <= '0;
      val_s1_q    <= 1'b0;
      vcm_cur_q   <= '0;
      vcm_valid_q <= 1'b0;
    end else begin
      cur_s1_q    <= cur_req;
      val_s1_q    <= cur_valid;
      vcm_cur_q   <= val_s1_q ? c_out : vcm_cur_q;
      vcm_valid_q <= val_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_ready_after_cal: assert property ($rose(drive_ready_q) |-> $past(cal_end))
    else $error("ready without finished calibration");
  chk_no_cmd_unready: assert property (!drive_ready_q |-> ##1 !cmd_start_q)
    else $error("command started before ready");
  chk_recal_starts: assert property (recal_tk |=> sa_rd_req_q && cal_busy_q && sa_zone_q == 0)
    else $error("recalibrate did not start calibration");
  chk_due_pending: assert property (due |=> pend_q || st_q == ST_SA)
    else $error("timed calibration lost");
  chk_interval_wrap: assert property (due |=> ms_q == 0 && tick_q == 0)
    else $error("interval counter did not restart");
  chk_preempt_fast: assert property (preempt |=> cmd_start_q && st_q == ST_CMD && pend_q)
    else $error("timed calibration not pre-empted");
  chk_preempt_wait: assert property (cmd_req && drive_ready_q && cal_act && timed_q
                                     && !cmd_recal |-> ##1 cmd_start_q)
    else $error("command wait too long");
  chk_restart_cal: assert property (st_q == ST_CMD && cmd_done && pend_q && !cmd_req
                                    |=> st_q == ST_SA && zone_q == 0 && sa_rd_req_q)
    else $error("calibration not restarted");
  chk_zone_walk: assert property (tbl_wr && zone_q != LAST_ZONE
                                  |=> zone_q == $past(zone_q) + 1 && sa_rd_req_q)
    else $error("zone sequence broken");
  chk_meas_window: assert property (tbl_wr |-> $past(dist_en_q))
    else $error("table write without measurement");
  chk_cur_latency: assert property (cur_valid |-> ##2 vcm_valid_q)
    else $error("compensated current late");
  chk_last_zone: assert property (tbl_wr |-> int'(zone_q) < ZONES)
    else $error("zone index beyond table");
  chk_due_in_cmd: assert property (due && st_q == ST_CMD |=> pend_q)
    else $error("due calibration not held");
  chk_pend_kept: assert property (pend_q && cal_act |=> pend_q)
    else $error("queued calibration lost");
  cov_preempt: cover property (preempt ##[1:50] (st_q == ST_CMD && cmd_done));
  cov_recal: cover property (recal_tk ##[1:200] recal_done_q);
  cov_first_ready: cover property ($rose(drive_ready_q));
endmodule // scs_self_cal

`default_nettype wire

// [rtl/scs_params.svh]
// Constants of the self-calibration scheduler.
// Assumes one drive clock of 125 MHz; included by bare name.
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// Clock and timechart
`define SCS_CLK_PERIOD_NS    8
`define SCS_TICK_NS          1000000
`define SCS_TICK_CYCLES      (`SCS_TICK_NS / `SCS_CLK_PERIOD_NS)
`define SCS_CAL_INTERVAL_MIN 30
`define SCS_MS_PER_MIN       60000
`define SCS_INTERVAL_TICKS   (`SCS_CAL_INTERVAL_MIN * `SCS_MS_PER_MIN)

// Zone tables
`define SCS_ZONES            14
`define SCS_ZONE_W           4
`define SCS_DATA_W           16

// Fixed-point gain ratio, target gain equals one
`define SCS_GAIN_FRAC        14
`define SCS_GAIN_ONE         16'h4000
`define SCS_FORCE_ZERO       16'h0000

`endif

// [rtl/scs_pkg.sv]
// Types of the self-calibration scheduler.
// Assumes nothing beyond the compile order.
`include "scs_params.svh"
package scs_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SA   = 5'b00010,
    ST_MEAS = 5'b00100,
    ST_WR   = 5'b01000,
    ST_CMD  = 5'b10000
  } scs_state_t;

  typedef logic [`SCS_ZONE_W-1:0] scs_zone_t;

endpackage

// [rtl/scs_zone_mem.sv]
// Per-zone table with one write port and a registered read port.
// Assumes writer and reader share ref_clk.
`timescale 1ns/1ps
`default_nettype none

module scs_zone_mem #(
  parameter int              W     = 16,
  parameter int              DEPTH = 14,
  parameter int              AW    = 4,
  parameter logic [W-1:0]    INIT  = '0
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [W-1:0]  rd_data_q
);

  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= INIT;
      end
    end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= INIT;
    end else if (int'(rd_addr) < DEPTH) begin
      rd_data_q <= mem_q[rd_addr];
    end else begin
      rd_data_q <= INIT;
    end
  end

endmodule // scs_zone_mem

`default_nettype wire

// [testbench/scs_far_model.sv]
// Far side model: system area reader and disturbance measurement.
// Assumes the scheduler's request outputs on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module scs_far_model (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // System area
  input  wire logic               sa_rd_req_q,
  input  wire scs_pkg::scs_zone_t sa_zone_q,
  output var  logic               sa_rd_valid,
  output var  logic [15:0]        sa_force,
  output var  logic [15:0]        sa_gain,
  // Measurement
  input  wire logic               dist_en_q,
  output var  logic               meas_valid,
  output var  logic [15:0]        meas_force,
  output var  logic [15:0]        meas_gain
);
  import scs_pkg::*;
  logic [3:0] z_q;
  int         sa_cnt;
  int         ms_cnt;
  logic       ms_done;

  ////////////////////////////////////////////////////////////////////////
  // Answers prompt on even zones, slow on odd ones
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sa_cnt <= 0; ms_cnt <= 0; ms_done <= 1'b0; z_q <= 4'h0;
      sa_rd_valid <= 1'b0; meas_valid <= 1'b0;
      sa_force <= 16'h0000; sa_gain <= 16'h0000;
      meas_force <= 16'h0000; meas_gain <= 16'h0000;
    end else begin
      sa_rd_valid <= 1'b0;
      meas_valid  <= 1'b0;
      sa_force    <= ~sa_force;
      sa_gain     <= ~sa_gain;
      meas_force  <= ~meas_force;
      meas_gain   <= ~meas_gain;
      if (sa_rd_req_q) begin
        z_q    <= sa_zone_q;
        sa_cnt <= sa_zone_q[0] ? 3 : 1;
      end else if (sa_cnt == 1) begin
        sa_rd_valid <= 1'b1;
        sa_force    <= 16'({z_q, 4'h0});
        sa_gain     <= 16'h4000 + 16'({z_q, 8'h00});
        sa_cnt      <= 0;
      end else if (sa_cnt > 1) begin
        sa_cnt <= sa_cnt - 1;
      end
      if (!dist_en_q) begin
        ms_cnt <= 0; ms_done <= 1'b0;
      end else if (!ms_done) begin
        ms_cnt <= ms_cnt + 1;
        if (ms_cnt == int'(z_q[0])) begin
          meas_valid <= 1'b1;
          meas_force <= 16'h0001;
          meas_gain  <= 16'h4000;
          ms_done    <= 1'b1;
        end
      end
    end
  end
endmodule // scs_far_model
`default_nettype wire

// [testbench/tb.sv]
// Testbench of the self-calibration scheduler.
// Assumes short timechart parameters: due every 240 cycles.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import scs_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0;
  logic cmd_req = 1'b0, cmd_recal = 1'b0, cmd_done = 1'b0;
  logic cmd_start_q, recal_done_q, drive_ready_q, cal_busy_q;
  logic sa_rd_req_q, sa_rd_valid, dist_en_q, meas_valid, vcm_valid_q;
  logic cur_valid = 1'b0;
  logic [15:0] cur_req = 16'h0000, sa_force, sa_gain, meas_force, meas_gain, vcm_cur_q;
  scs_zone_t sa_zone_q, cur_zone = 4'h0;
  int num_errors = 0, checks = 0, cyc;

  scs_self_cal #(.TICK_CYCLES(4), .INTERVAL_TICKS(60)) u_scs_self_cal (
    .ref_clk(ref_clk), .reset_n(reset_n), .cmd_req(cmd_req), .cmd_recal(cmd_recal),
    .cmd_done(cmd_done), .cmd_start_q(cmd_start_q), .recal_done_q(recal_done_q),
    .drive_ready_q(drive_ready_q), .cal_busy_q(cal_busy_q), .sa_rd_req_q(sa_rd_req_q),
    .sa_zone_q(sa_zone_q), .sa_rd_valid(sa_rd_valid), .sa_force(sa_force), .sa_gain(sa_gain),
    .dist_en_q(dist_en_q), .meas_valid(meas_valid), .meas_force(meas_force),
    .meas_gain(meas_gain), .cur_valid(cur_valid), .cur_req(cur_req), .cur_zone(cur_zone),
    .vcm_valid_q(vcm_valid_q), .vcm_cur_q(vcm_cur_q)
  );
  scs_far_model u_scs_far_model (
    .ref_clk(ref_clk), .reset_n(reset_n), .sa_rd_req_q(sa_rd_req_q), .sa_zone_q(sa_zone_q),
    .sa_rd_valid(sa_rd_valid), .sa_force(sa_force), .sa_gain(sa_gain), .dist_en_q(dist_en_q),
    .meas_valid(meas_valid), .meas_force(meas_force), .meas_gain(meas_gain)
  );

  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk or negedge reset_n) cyc <= reset_n ? cyc + 1 : 0;

  ////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  function logic pick(input int k);
    case (k)
      0: return drive_ready_q;
      2: return recal_done_q;
      3: return sa_rd_req_q;
      default: return cal_busy_q === 1'b0;
    endcase
  endfunction
  task wait_hi(input int k, input int n);
    int i;
    for (i = 0; i < n && pick(k) !== 1'b1; i++) tick;
    if (pick(k) !== 1'b1) begin
      num_errors++;
      $display("BAD t=%0t wait expired", $time);
      report_and_stop;
    end
  endtask
  task cmd(input logic recal);
    cmd_req = 1'b1; cmd_recal = recal;
    tick;
    cmd_req = 1'b0; cmd_recal = 1'b0;
  endtask
  task done_pulse;
    cmd_done = 1'b1;
    tick;
    cmd_done = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task power_on;
    tick;
    chk(cal_busy_q, 1'b1);
    cmd(1'b0);
    chk(cmd_start_q, 1'b0);
    chk(drive_ready_q, 1'b0);
    wait_hi(0, 400);
    chk(cal_busy_q, 1'b0);
  endtask
  task tables;
    int z;
    for (z = 0; z < 16; z = (z == 13) ? 15 : z + 1) begin
      cur_valid = 1'b1; cur_req = 16'h0100; cur_zone = 4'(z);
      tick;
      cur_valid = 1'b0;
      tick;
      chk(vcm_valid_q, 1'b1);
      chk(vcm_cur_q, (z == 15) ? 16'h0100 : 16'(16'h0101 + z * 20));
    end
  endtask
  task timed_preempt;
    wait_hi(3, 300);
    chk(16'(cyc >= 239 && cyc <= 244), 16'h0001);
    repeat (15) tick;
    cmd(1'b0);
    chk(cmd_start_q, 1'b1);
    repeat (5) tick;
    done_pulse;
    wait_hi(3, 4);
    chk(sa_zone_q, 4'h0);
    wait_hi(4, 300);
  endtask
  task pending;
    while (cyc < 470) tick;
    cmd(1'b0);
    chk(cmd_start_q, 1'b1);
    while (cyc < 490) tick;
    chk(cal_busy_q, 1'b0);
    done_pulse;
    wait_hi(3, 4);
    chk(sa_rd_req_q, 1'b1);
    wait_hi(4, 300);
  endtask
  task recal;
    while (cyc < 680) tick;
    cmd(1'b1);
    chk(cmd_start_q, 1'b0);
    wait_hi(2, 400);
    chk(recal_done_q, 1'b1);
    wait_hi(4, 400);
    wait_hi(3, 4);
    chk(sa_rd_req_q, 1'b1);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    power_on;
    tables;
    timed_preempt;
    pending;
    recal;
    tables;
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
